/* src/sss_sram_ctrl.sv */
// select, write and sleep control of a small synchronous sram
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - selected only for low, high, low selects
// - global write, or byte write gate with all lanes, writes full word
// - bus stays released after write until strobe read
// - data lines released on leaving sleep
module sss_sram_ctrl #(
	parameter int ADDR_W = sss_pkg::ADDR_W
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire sss_pkg::sss_ctrl_t ctrl_pins,
	input wire logic sleep_request,
	input wire logic [ADDR_W-1:0] addr_pins,
	input wire logic [31:0] dq_in,
	output logic [31:0] dq_out,
	output logic dq_oe,
	output logic sleeping
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	sss_pkg::sss_ctrl_t ctrl_m_ff, ctrl_ff; // two stages
	logic sleep_m_ff, sleep_s_ff; // sleep request sync
	logic [ADDR_W-1:0] addr_m_ff, addr_ff; // address sync
	logic [31:0] din_m_ff, din_ff; // write data sync

	// first stage feeds only the second
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_m_ff <= '1;
			ctrl_ff <= '1;
			sleep_m_ff <= sss_pkg::RST_SLEEP;
			sleep_s_ff <= sss_pkg::RST_SLEEP;
			addr_m_ff <= '0;
			addr_ff <= '0;
			din_m_ff <= sss_pkg::RST_DATA;
			din_ff <= sss_pkg::RST_DATA;
		end else begin
			ctrl_m_ff <= ctrl_pins;
			ctrl_ff <= ctrl_m_ff;
			sleep_m_ff <= sleep_request;
			sleep_s_ff <= sleep_m_ff;
			addr_m_ff <= addr_pins;
			addr_ff <= addr_m_ff;
			din_m_ff <= dq_in;
			din_ff <= din_m_ff;
		end
	end

	// ----------------------------------------
	// decode
	// ----------------------------------------
	// three-way select match
	wire selected = !ctrl_ff.pipelined_chip_select_n
		&& ctrl_ff.expansion_select_high
		&& !ctrl_ff.expansion_select_low_n;
	wire strobe = !ctrl_ff.processor_address_strobe_n
		|| !ctrl_ff.controller_address_strobe_n;
	wire [3:0] lane_we; // per-lane write enables
	wire any_we = |lane_we;
	// a processor strobe always reads; writes come via controller strobe
	wire wr_start = selected && !ctrl_ff.controller_address_strobe_n
		&& ctrl_ff.processor_address_strobe_n && any_we;
	wire rd_start = selected && strobe && !wr_start;

	sss_lane_enable u_lane (
		.global_write_n(ctrl_ff.global_write_n),
		.byte_write_gate_n(ctrl_ff.byte_write_gate_n),
		.byte_lane_write_n(ctrl_ff.byte_lane_write_n),
		.lane_we(lane_we)
	);

	// ----------------------------------------
	// storage and state
	// ----------------------------------------
	logic [31:0] mem_ff [2**ADDR_W]; // flip-flop array
	sss_pkg::sss_state_t state_ff, nxt_state; // cycle kind
	logic dq_oe_ff, nxt_dq_oe; // bus drive
	logic [31:0] dq_out_ff; // read data
	logic sleeping_ff; // sleep indication

	// next state: sleep beats everything
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			sss_pkg::SSS_SLEEP: begin
				// wake returns to idle, bus released
				if (!sleep_s_ff) nxt_state = sss_pkg::SSS_IDLE;
			end
			default: begin
				if (sleep_s_ff) nxt_state = sss_pkg::SSS_SLEEP;
				else if (wr_start) nxt_state = sss_pkg::SSS_WRITE;
				else if (rd_start) nxt_state = sss_pkg::SSS_READ;
				else if (strobe && !selected) nxt_state = sss_pkg::SSS_IDLE;
			end
		endcase
	end

	// bus drive only in read state
	assign nxt_dq_oe = (nxt_state == sss_pkg::SSS_READ);

	// state and bus drive registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_ff <= sss_pkg::SSS_IDLE;
			dq_oe_ff <= sss_pkg::RST_DRIVE;
			sleeping_ff <= sss_pkg::RST_SLEEP;
		end else begin
			state_ff <= nxt_state;
			// released after write until a strobed read
			dq_oe_ff <= nxt_dq_oe;
			sleeping_ff <= (nxt_state == sss_pkg::SSS_SLEEP);
		end
	end

	// write lanes; no reset on the array to keep it small
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < 4; i++) begin
			if (wr_start && lane_we[i] && state_ff != sss_pkg::SSS_SLEEP)
				mem_ff[addr_ff][i*8 +: 8] <= din_ff[i*8 +: 8];
		end
	end

	// read data register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) dq_out_ff <= sss_pkg::RST_DATA;
		else if (rd_start) dq_out_ff <= mem_ff[addr_ff];
	end

	assign dq_out = dq_out_ff;
	assign dq_oe = dq_oe_ff;
	assign sleeping = sleeping_ff;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_sel_read;
		@(posedge ref_clk) disable iff (rst)
		(rd_start && !sleep_s_ff && state_ff != sss_pkg::SSS_SLEEP)
		|=> dq_oe;
	endproperty
	a_sel_read: assert property (p_sel_read)
		else $error("strobed selected read did not drive bus");

	property p_desel_quiet;
		@(posedge ref_clk) disable iff (rst)
		(ctrl_ff.pipelined_chip_select_n || !ctrl_ff.expansion_select_high
		|| ctrl_ff.expansion_select_low_n) |-> !wr_start && !rd_start;
	endproperty
	a_desel_quiet: assert property (p_desel_quiet)
		else $error("deselected pins started an access");

	property p_full_write;
		@(posedge ref_clk) disable iff (rst)
		(!ctrl_ff.global_write_n || (!ctrl_ff.byte_write_gate_n
		&& ctrl_ff.byte_lane_write_n == 4'h0)) |-> lane_we == 4'hf;
	endproperty
	a_full_write: assert property (p_full_write)
		else $error("full width write not decoded");

	property p_wr_release;
		@(posedge ref_clk) disable iff (rst)
		(state_ff == sss_pkg::SSS_WRITE) ##0 (!rd_start) |=> !dq_oe;
	endproperty
	a_wr_release: assert property (p_wr_release)
		else $error("bus driven after write without read");

	property p_wake_hiz;
		@(posedge ref_clk) disable iff (rst)
		$fell(sleeping) |-> !dq_oe ##1 !dq_oe;
	endproperty
	a_wake_hiz: assert property (p_wake_hiz)
		else $error("data lines driven on leaving sleep");

	property p_gated_lanes;
		@(posedge ref_clk) disable iff (rst)
		(ctrl_ff.global_write_n && !ctrl_ff.byte_write_gate_n)
		|-> lane_we == ~ctrl_ff.byte_lane_write_n;
	endproperty
	a_gated_lanes: assert property (p_gated_lanes)
		else $error("gated write lanes wrong");

	property p_sleep_hiz;
		@(posedge ref_clk) disable iff (rst)
		sleeping |-> !dq_oe;
	endproperty
	a_sleep_hiz: assert property (p_sleep_hiz)
		else $error("bus driven while asleep");

	property p_no_gate_no_write;
		@(posedge ref_clk) disable iff (rst)
		(ctrl_ff.global_write_n && ctrl_ff.byte_write_gate_n)
		|-> lane_we == 4'h0;
	endproperty
	a_no_gate_no_write: assert property (p_no_gate_no_write)
		else $error("write without any write enable");

	c_read: cover property (@(posedge ref_clk) disable iff (rst)
		rd_start ##1 dq_oe);
	c_write_then_read: cover property (@(posedge ref_clk)
		disable iff (rst) wr_start ##[1:4] rd_start);
	c_sleep_wake: cover property (@(posedge ref_clk) disable iff (rst)
		sleeping ##1 !sleeping);
endmodule
`default_nettype wire

/* pkg/sss_pkg.sv */
// shared constants and carrier types for the select/write/sleep sram control
package sss_pkg;
	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int ADDR_W = 6;
	localparam int LANES = 4;
	localparam int LANE_W = 8;
	localparam int DATA_W = LANES * LANE_W;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic RST_DRIVE = 1'b0;
	localparam logic RST_SLEEP = 1'b0;
	localparam logic [31:0] RST_DATA = 32'h0000_0000;

	// bus-side control pins, synchronised inside the controller by two stages
	typedef struct packed {
		logic pipelined_chip_select_n;
		logic expansion_select_high;
		logic expansion_select_low_n;
		logic processor_address_strobe_n;
		logic controller_address_strobe_n;
		logic global_write_n;
		logic byte_write_gate_n;
		logic [3:0] byte_lane_write_n;
	} sss_ctrl_t;

	// cycle kinds
	typedef enum logic [1:0] {
		SSS_IDLE,
		SSS_READ,
		SSS_WRITE,
		SSS_SLEEP
	} sss_state_t;
endpackage

/* src/sss_lane_enable.sv */
// byte-lane write enable decoder
`timescale 1ns/1ps
`default_nettype none
module sss_lane_enable (
	input wire logic global_write_n,
	input wire logic byte_write_gate_n,
	input wire logic [3:0] byte_lane_write_n,
	output wire logic [3:0] lane_we
);
	genvar g;
	// ----------------------------------------
	// per-lane decode
	// ----------------------------------------
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			assign lane_we[g] = !global_write_n
				|| (!byte_write_gate_n && !byte_lane_write_n[g]);
		end
	endgenerate
endmodule
`default_nettype wire

/* verification/sss_host_model.sv */
// host bus model driving the sram control pins
`timescale 1ns/1ps
`default_nettype none
module sss_host_model (
	input wire logic ref_clk,
	output var sss_pkg::sss_ctrl_t ctrl_pins,
	output var logic sleep_request,
	output var logic [5:0] addr_pins,
	output var logic [31:0] dq_in
);
	// ----------------------------------------
	// idle bus
	// ----------------------------------------
	// all ones: deselected, no strobe
	initial begin
		ctrl_pins = '1;
		sleep_request = 1'b0;
		addr_pins = 6'h00;
		dq_in = 32'hffff_ffff;
	end
	// one strobed cycle; released address and data lines show the inverse
	// write pin combos
	task automatic cyc(input sss_pkg::sss_ctrl_t c, input logic [5:0] a,
		input logic [31:0] d);
		@(negedge ref_clk);
		ctrl_pins = c;
		addr_pins = a;
		dq_in = d;
		@(negedge ref_clk);
		ctrl_pins = '1;
		addr_pins = ~a;
		dq_in = ~d;
	endtask
	// raise or drop the sleep request
	// deselect before sleep
	task automatic zz(input logic on);
		@(negedge ref_clk);
		ctrl_pins = '1;
		@(negedge ref_clk);
		sleep_request = on;
	endtask
endmodule
`default_nettype wire

/* verification/tb_sync_sram_select_write_sleep.sv */
// self-checking bench for the sram select, write and sleep control
`timescale 1ns/1ps
`default_nettype none
module tb_sync_sram_select_write_sleep;
	logic ref_clk, rst, sleep_request, dq_oe, sleeping;
	sss_pkg::sss_ctrl_t ctrl_pins; // bundled bus pins
	logic [5:0] addr_pins;
	logic [31:0] dq_in, dq_out, q;
	logic oe;
	int num_errors = 0;
	int samples_checked = 0;
	sss_host_model host_u (.ref_clk(ref_clk), .ctrl_pins(ctrl_pins),
		.sleep_request(sleep_request), .addr_pins(addr_pins),
		.dq_in(dq_in));
	sss_sram_ctrl #(.ADDR_W(6)) dut_u (.ref_clk(ref_clk), .rst(rst),
		.ctrl_pins(ctrl_pins), .sleep_request(sleep_request),
		.addr_pins(addr_pins), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe(dq_oe), .sleeping(sleeping));
	// ----------------------------------------
	// clock, compare, verdict
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic check(input string what, input logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic complete_run;
		if (num_errors == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	// one access; outputs move on the third rising edge after the pin edge
	// sampled a cycle later, where they are settled
	task automatic look(input sss_pkg::sss_ctrl_t c, input logic [5:0] a,
		input logic [31:0] d);
		host_u.cyc(c, a, d);
		repeat (3) @(negedge ref_clk);
		q = dq_out;
		oe = dq_oe;
	endtask
	// processor-strobe read with the given three select pins
	task automatic rd(input logic [2:0] s, input logic [5:0] a);
		look({s, 8'h7f}, a, 32'h0000_0000);
	endtask
	// controller-strobe write; w is global, gate, then four lane selects
	task automatic wr(input logic [5:0] w, a, input logic [31:0] d);
		look({3'b010, 2'b10, w}, a, d);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_select;
		wr(6'h0f, 6'h05, 32'h1234_5678);
		for (int i = 0; i < 8; i++) begin
			rd(3'(i), 6'h05);
			check("oe", 32'(oe), 32'(i == 2));
			if (i == 2) check("q", q, 32'h1234_5678);
		end
	endtask
	task automatic t_write;
		wr(6'h0f, 6'h01, 32'h1122_3344);
		wr(6'h20, 6'h02, 32'h5566_7788);
		wr(6'h2a, 6'h01, 32'haaaa_aaaa);
		rd(3'b010, 6'h01);
		check("gated", q, 32'h11aa_33aa);
		rd(3'b010, 6'h02);
		check("lanes", q, 32'h5566_7788);
	endtask
	task automatic t_release;
		wr(6'h0f, 6'h03, 32'hc0de_0003);
		check("oe_wr", 32'(dq_oe), 32'h0);
		repeat (4) @(negedge ref_clk);
		check("oe_idle", 32'(dq_oe), 32'h0);
		rd(3'b010, 6'h03);
		check("oe_rd", 32'(oe), 32'h1);
		// controller strobe with no lane enable reads after a write
		wr(6'h0f, 6'h04, 32'hc0de_0004);
		look({3'b010, 2'b10, 6'h3f}, 6'h04, 32'h0000_0000);
		check("oe_ctl", 32'(oe), 32'h1);
		check("q_ctl", q, 32'hc0de_0004);
		// processor strobe reads even with global write low
		wr(6'h0f, 6'h04, 32'hc0de_0004);
		look({3'b010, 2'b01, 6'h0f}, 6'h04, 32'hdead_0004);
		check("oe_prc", 32'(oe), 32'h1);
		rd(3'b010, 6'h04);
		check("q_prc", q, 32'hc0de_0004);
	endtask
	task automatic t_sleep;
		rd(3'b010, 6'h03);
		host_u.zz(1'b1);
		repeat (4) @(negedge ref_clk);
		check("asleep", 32'(sleeping), 32'h1);
		// a strobed read while asleep must leave the bus released
		rd(3'b010, 6'h03);
		check("oe_zz", 32'(oe), 32'h0);
		check("still", 32'(sleeping), 32'h1);
		host_u.zz(1'b0);
		repeat (4) @(negedge ref_clk);
		check("awake", 32'(sleeping), 32'h0);
		check("oe_wake", 32'(dq_oe), 32'h0);
		// after waking only a new strobed read drives again
		rd(3'b010, 6'h03);
		check("oe_back", 32'(oe), 32'h1);
		check("q_back", q, 32'hc0de_0003);
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		repeat (16) @(negedge ref_clk);
		rst = 1'b0;
		check("rst_oe", 32'(dq_oe), 32'(sss_pkg::RST_DRIVE));
		check("rst_q", dq_out, sss_pkg::RST_DATA);
		t_select();
		t_write();
		t_release();
		t_sleep();
		complete_run();
	end
	// run needs a few hundred cycles at most
	initial begin
		#50000;
		num_errors++;
		complete_run();
	end
endmodule
`default_nettype wire
